// ==== rtl/difd_pkg.sv ====
// Constants shared by the terminal function decoder: function codes,
// register offsets, status bit positions, defaults and timing.
// Assumes a 100 MHz system clock and a byte-addressed 32-bit Avalon-MM slave.
package difd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NTERM = 4;
  localparam int CODE_W = 6;
  localparam int NFUNC = 33;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 22;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_RESET = 6'h01;
  localparam logic [5:0] FN_COAST_INV = 6'h02;
  localparam logic [5:0] FN_RST_COAST_INV = 6'h03;
  localparam logic [5:0] FN_QUICK_INV = 6'h04;
  localparam logic [5:0] FN_DCB_INV = 6'h05;
  localparam logic [5:0] FN_STOP_INV = 6'h06;
  localparam logic [5:0] FN_START = 6'h07;
  localparam logic [5:0] FN_LATCH_START = 6'h08;
  localparam logic [5:0] FN_REVERSE = 6'h09;
  localparam logic [5:0] FN_START_REV = 6'h0a;
  localparam logic [5:0] FN_EN_FWD = 6'h0b;
  localparam logic [5:0] FN_EN_REV = 6'h0c;
  localparam logic [5:0] FN_INCH = 6'h0d;
  localparam logic [5:0] FN_FREEZE_REF = 6'h0e;
  localparam logic [5:0] FN_FREEZE_OUT = 6'h0f;
  localparam logic [5:0] FN_SPEED_UP = 6'h10;
  localparam logic [5:0] FN_SPEED_DN = 6'h11;
  localparam logic [5:0] FN_SETUP_SEL = 6'h12;
  localparam logic [5:0] FN_CATCH_UP = 6'h13;
  localparam logic [5:0] FN_SLOW_DN = 6'h14;
  localparam logic [5:0] FN_PRESET_SEL = 6'h15;
  localparam logic [5:0] FN_PRESET_EN = 6'h16;
  localparam logic [5:0] FN_PRECISE_STOP = 6'h17;
  localparam logic [5:0] FN_PULSE_REF = 6'h18;
  localparam logic [5:0] FN_PULSE_FB = 6'h19;
  localparam logic [5:0] FN_ANA_REF = 6'h1e;
  localparam logic [5:0] FN_ANA_FB = 6'h1f;
  localparam logic [5:0] FN_RESET_START = 6'h20;

  // Terminal index (0 = terminal two) that owns each restricted code
  localparam int TIDX_ANALOG = 0;
  localparam int TIDX_PULSE = 1;
  localparam int TIDX_PRECISE = 2;

  // Factory functions, terminals two to five
  localparam logic [5:0] DEF_T2 = FN_ANA_REF;
  localparam logic [5:0] DEF_T3 = FN_RESET;
  localparam logic [5:0] DEF_T4 = FN_START;
  localparam logic [5:0] DEF_T5 = FN_INCH;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FUNC_T2 = 8'h00;
  localparam logic [7:0] OFS_FUNC_T3 = 8'h04;
  localparam logic [7:0] OFS_FUNC_T4 = 8'h08;
  localparam logic [7:0] OFS_FUNC_T5 = 8'h0c;
  localparam logic [7:0] OFS_RESTORE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_LEVELS = 8'h18;
  localparam int RESTORE_BIT = 0;

  // Status bit positions
  localparam int ST_COAST = 0;
  localparam int ST_ALARM_CLR = 1;
  localparam int ST_QUICK = 2;
  localparam int ST_DCB = 3;
  localparam int ST_RAMP_STOP = 4;
  localparam int ST_RUN = 5;
  localparam int ST_REV = 6;
  localparam int ST_INCH = 7;
  localparam int ST_FRZ_REF = 8;
  localparam int ST_FRZ_OUT = 9;
  localparam int ST_UP_RAMP = 10;
  localparam int ST_DN_RAMP = 11;
  localparam int ST_SETUP = 12;
  localparam int ST_CATCH = 13;
  localparam int ST_SLOW = 14;
  localparam int ST_PRE_SEL = 15;
  localparam int ST_PRE_EN = 16;
  localparam int ST_PRECISE = 17;
  localparam int ST_LATCHED = 18;
  localparam int ST_REF_MASK = 20;
  localparam int ST_FB_MASK = 24;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int PULSE_MIN_MS = 20;
  localparam int PULSE_MIN_CYC = PULSE_MIN_MS * CLK_KHZ;

endpackage : difd_pkg

// ==== rtl/difd_pulse_qual.sv ====
// Pulse qualifier for one decoded terminal level.
// Assumes lvl is already synchronous to sys_clk; min_cyc is at least one.
`timescale 1ns/1ps
`default_nettype none

module difd_pulse_qual (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic lvl,
  input wire logic [21:0] min_cyc,
  output var logic long_q,
  output var logic step_q
);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_HIGH = 4'b0010,
    S_LONG = 4'b0100,
    S_GAP = 4'b1000
  } difd_qstate_e;

  difd_qstate_e state_q;
  difd_qstate_e state_d;
  logic [21:0] cnt_q;
  logic [21:0] cnt_d;
  logic long_d;
  logic step_d;
  logic reach;

  assign reach = (cnt_q >= (min_cyc - 22'h00_0001));

  // High phase must last min_cyc, then a low gap of min_cyc gives one step
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    long_d = 1'b0;
    step_d = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        cnt_d = '0;
        if (lvl)
        begin
          // First high cycle counts, so exactly min_cyc qualifies
          state_d = S_HIGH;
          cnt_d = 22'h00_0001;
        end
      end
      S_HIGH:
      begin
        if (!lvl)
        begin
          state_d = S_IDLE;
          cnt_d = '0;
        end
        else if (reach)
        begin
          state_d = S_LONG;
          long_d = 1'b1;
          cnt_d = '0;
        end
        else
          cnt_d = cnt_q + 22'h00_0001;
      end
      S_LONG:
      begin
        cnt_d = '0;
        if (!lvl)
        begin
          state_d = S_GAP;
          cnt_d = 22'h00_0001;
        end
      end
      S_GAP:
      begin
        if (lvl)
        begin
          // Gap too short: the pulse is not a step
          state_d = S_HIGH;
          cnt_d = 22'h00_0001;
        end
        else if (reach)
        begin
          state_d = S_IDLE;
          step_d = 1'b1;
          cnt_d = '0;
        end
        else
          cnt_d = cnt_q + 22'h00_0001;
      end
      default:
      begin
        state_d = S_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      long_q <= 1'b0;
      step_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      long_q <= long_d;
      step_q <= step_d;
    end
  end

endmodule : difd_pulse_qual

`default_nettype wire

// ==== rtl/difd_top.sv ====
// Digital input function decoder: four terminals, per-terminal function
// codes over Avalon-MM, decoded drive commands as registered outputs.
// Assumes terminal pins are asynchronous and core status inputs are on sys_clk.
//
// How it works
// R1: Each terminal two to five has own code.
// R2: Codes 0..22 and 32 legal everywhere.
// R3: Codes 23, 24-25, 30-31 terminal-restricted.
// R4: Factory restore: 30, 1, 7, 13.
// R5: Code zero produces no command.
// R6: Reset clears alarm unless power-cycle class.
// R7: Coast inverse low releases motor.
// R8: Combined inverse low coasts and clears alarm.
// R9: Quick-stop inverse low commands quick ramp.
// R10: Direct_current_braking_low low only when configured.
// R11: Stop inverse low blocks run, ramps down.
// R12: Start high runs, low stands by.
// R13: Latched start needs 20 ms high pulse.
// R14: Reversing sets direction, never starts.
// R15: Start-reversing runs reversed, latches with latch-start.
// R16: Direction enables permit only their direction.
// R17: Avoid direction functions in closed-loop process mode.
// R18: Inch forces jog, ignored under stop.
// R19: Freeze reference holds; up/down adjust it.
// R20: Freeze output holds frequency for up/down.
// R21: Multiple reference/feedback terminals are summed.
// R22: Held up/down ramps; qualified pulse steps.
// R23: Up/down only act while frozen.
// R24: Preset enable and preset select choose reference.
// R25: Catch-up adds, slow-down subtracts, both subtract.
// R26: Synchronise terminals, update all together.
`timescale 1ns/1ps
`default_nettype none

module difd_top #(
  parameter logic [21:0] PULSE_MIN_CYC = 22'(difd_pkg::PULSE_MIN_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  input wire logic [3:0] term_in,
  input wire logic alarm_active,
  input wire logic alarm_power_cycle_only,
  input wire logic dc_brake_configured,
  output var logic free_run_halt_q,
  output var logic alarm_clear_q,
  output var logic quick_stop_q,
  output var logic direct_current_braking_q,
  output var logic ramp_stop_q,
  output var logic run_q,
  output var logic reverse_q,
  output var logic inch_speed_override_q,
  output var logic freeze_ref_q,
  output var logic freeze_out_q,
  output var logic speed_up_ramp_q,
  output var logic speed_down_ramp_q,
  output var logic speed_up_step_q,
  output var logic speed_down_step_q,
  output var logic setup_select_q,
  output var logic catch_up_q,
  output var logic slow_down_q,
  output var logic preset_select_q,
  output var logic preset_enable_q,
  output var logic precise_stop_q,
  output var logic [3:0] ref_sum_mask_q,
  output var logic [3:0] fb_sum_mask_q
);

  localparam int NT = difd_pkg::NTERM;
  localparam int NF = difd_pkg::NFUNC;
  localparam int CW = difd_pkg::CODE_W;

  // ----------------------------------------------------------------
  // Terminal synchronisers
  // ----------------------------------------------------------------
  logic [NT-1:0] s1_q;
  logic [NT-1:0] s2_q;
  logic [NT-1:0] s3_q;
  logic [NT-1:0] lvl_q;
  logic [NT-1:0] agree;

  // A level change counts once the second and third stages agree
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= term_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (agree & s2_q) | (~agree & lvl_q); // R26
    end
  end

  // ----------------------------------------------------------------
  // Function code registers
  // ----------------------------------------------------------------
  logic [NT-1:0][CW-1:0] code_q;
  logic [NT-1:0] code_sel;
  logic [NT-1:0] code_ok;
  logic wr_take;
  logic rd_take;
  logic restore_hit;
  logic [CW-1:0] wcode;

  // Legality of a code on a given terminal index
  function automatic logic code_legal(input int t, input logic [CW-1:0] c);
    logic ok;
    ok = (c <= difd_pkg::FN_PRESET_EN) || (c == difd_pkg::FN_RESET_START); // R2
    if (c == difd_pkg::FN_PRECISE_STOP)
      ok = (t == difd_pkg::TIDX_PRECISE); // R3
    if ((c == difd_pkg::FN_PULSE_REF) || (c == difd_pkg::FN_PULSE_FB))
      ok = (t == difd_pkg::TIDX_PULSE); // R3
    if ((c == difd_pkg::FN_ANA_REF) || (c == difd_pkg::FN_ANA_FB))
      ok = (t == difd_pkg::TIDX_ANALOG); // R3
    return ok;
  endfunction : code_legal

  // Write strobes; a write lands on the edge where waitrequest is low
  assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_take = avs_read && avs_waitrequest;
  assign wcode = avs_writedata[CW-1:0];
  assign restore_hit = wr_take && (avs_address == difd_pkg::OFS_RESTORE) &&
                       avs_writedata[difd_pkg::RESTORE_BIT];

  genvar gt;
  generate
    for (gt = 0; gt < NT; gt++)
    begin : g_code
      // Offsets are word-spaced from the first terminal's register
      assign code_sel[gt] = wr_take &&
                            (avs_address == (difd_pkg::OFS_FUNC_T2 + 8'(4 * gt))); // R1
      assign code_ok[gt] = code_legal(gt, wcode);
    end
  endgenerate

  // Illegal codes are dropped so a terminal never holds a foreign function
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_q <= {difd_pkg::DEF_T5, difd_pkg::DEF_T4, difd_pkg::DEF_T3, difd_pkg::DEF_T2}; // R4
    end
    else if (restore_hit)
    begin
      code_q <= {difd_pkg::DEF_T5, difd_pkg::DEF_T4, difd_pkg::DEF_T3, difd_pkg::DEF_T2}; // R4
    end
    else
    begin
      for (int t = 0; t < NT; t++)
        if (code_sel[t] && code_ok[t])
          code_q[t] <= wcode; // R3
    end
  end

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  logic [NF-1:0] hi;
  logic [NF-1:0] lo;
  logic [NF-1:0] used;
  logic [NF-1:0][NT-1:0] asg;

  // Code zero is decoded but never read, so it yields no command
  genvar gf;
  generate
    for (gf = 0; gf < NF; gf++)
    begin : g_fn
      for (gt = 0; gt < NT; gt++)
      begin : g_t
        assign asg[gf][gt] = (code_q[gt] == CW'(gf)); // R1
      end
      assign hi[gf] = |(asg[gf] & lvl_q); // R5
      assign lo[gf] = |(asg[gf] & ~lvl_q);
      assign used[gf] = |asg[gf];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pulse qualifiers: latched start, speed up, speed down
  // ----------------------------------------------------------------
  logic latch_long;
  logic up_step;
  logic dn_step;

  difd_pulse_qual u_q_latch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lvl(hi[difd_pkg::FN_LATCH_START]),
    .min_cyc(PULSE_MIN_CYC),
    .long_q(latch_long),
    .step_q()
  );

  difd_pulse_qual u_q_up (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lvl(hi[difd_pkg::FN_SPEED_UP]),
    .min_cyc(PULSE_MIN_CYC),
    .long_q(),
    .step_q(up_step)
  );

  difd_pulse_qual u_q_dn (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lvl(hi[difd_pkg::FN_SPEED_DN]),
    .min_cyc(PULSE_MIN_CYC),
    .long_q(),
    .step_q(dn_step)
  );

  // ----------------------------------------------------------------
  // Command derivation
  // ----------------------------------------------------------------
  logic coast_d;
  logic quick_d;
  logic dcb_d;
  logic rstop_d;
  logic stop_any;
  logic clr_d;
  logic srev_plain;
  logic srev_latches;
  logic conflict;
  logic latch_run_q;
  logic latch_rev_q;
  logic srev_prev_q;
  logic dir_rev;
  logic dir_ok;
  logic run_req;
  logic frozen;
  logic [NT-1:0] ref_mask;
  logic [NT-1:0] fb_mask;

  assign coast_d = lo[difd_pkg::FN_COAST_INV] | lo[difd_pkg::FN_RST_COAST_INV]; // R7 R8
  assign quick_d = lo[difd_pkg::FN_QUICK_INV]; // R9
  assign dcb_d = lo[difd_pkg::FN_DCB_INV] & dc_brake_configured; // R10
  assign rstop_d = lo[difd_pkg::FN_STOP_INV]; // R11
  assign stop_any = coast_d | quick_d | dcb_d | rstop_d;
  // Power-cycle-only alarms cannot be cleared from a terminal
  assign clr_d = (hi[difd_pkg::FN_RESET] | lo[difd_pkg::FN_RST_COAST_INV] |
                  hi[difd_pkg::FN_RESET_START]) & alarm_active & ~alarm_power_cycle_only; // R6 R8

  // Start-reversing latches only when latched start sits on another terminal
  assign srev_latches = used[difd_pkg::FN_LATCH_START]; // R15
  assign srev_plain = hi[difd_pkg::FN_START_REV] & ~srev_latches;
  // Plain start and start-reversing together are treated as no start
  assign conflict = hi[difd_pkg::FN_START] & hi[difd_pkg::FN_START_REV]; // R15
  assign dir_rev = hi[difd_pkg::FN_REVERSE] | srev_plain | latch_rev_q; // R14 R15
  assign dir_ok = dir_rev ? (~used[difd_pkg::FN_EN_REV] | hi[difd_pkg::FN_EN_REV]) :
                            (~used[difd_pkg::FN_EN_FWD] | hi[difd_pkg::FN_EN_FWD]); // R16
  // Reversing alone is not part of the run request
  assign run_req = hi[difd_pkg::FN_START] | srev_plain | latch_run_q | latch_rev_q |
                   hi[difd_pkg::FN_RESET_START]; // R12 R14
  assign frozen = hi[difd_pkg::FN_FREEZE_REF] | hi[difd_pkg::FN_FREEZE_OUT]; // R23

  // Which terminals feed the summed reference and feedback
  generate
    for (gt = 0; gt < NT; gt++)
    begin : g_mask
      assign ref_mask[gt] = (code_q[gt] == difd_pkg::FN_ANA_REF) ||
                            (code_q[gt] == difd_pkg::FN_PULSE_REF); // R21
      assign fb_mask[gt] = (code_q[gt] == difd_pkg::FN_ANA_FB) ||
                           (code_q[gt] == difd_pkg::FN_PULSE_FB); // R21
    end
  endgenerate

  // Latches: any stop command except precise stop releases them, and a stop wins over a set
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_run_q <= 1'b0;
      latch_rev_q <= 1'b0;
      srev_prev_q <= 1'b0;
    end
    else
    begin
      srev_prev_q <= hi[difd_pkg::FN_START_REV];
      if (stop_any)
      begin
        latch_run_q <= 1'b0; // R13
        latch_rev_q <= 1'b0;
      end
      else
      begin
        if (latch_long)
          latch_run_q <= 1'b1; // R13
        if (srev_latches && hi[difd_pkg::FN_START_REV] && !srev_prev_q)
          latch_rev_q <= 1'b1; // R15
      end
    end
  end

  // All commands register together from one set of synced levels
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      free_run_halt_q <= 1'b0;
      alarm_clear_q <= 1'b0;
      quick_stop_q <= 1'b0;
      direct_current_braking_q <= 1'b0;
      ramp_stop_q <= 1'b0;
      run_q <= 1'b0;
      reverse_q <= 1'b0;
      inch_speed_override_q <= 1'b0;
      freeze_ref_q <= 1'b0;
      freeze_out_q <= 1'b0;
      speed_up_ramp_q <= 1'b0;
      speed_down_ramp_q <= 1'b0;
      speed_up_step_q <= 1'b0;
      speed_down_step_q <= 1'b0;
      setup_select_q <= 1'b0;
      catch_up_q <= 1'b0;
      slow_down_q <= 1'b0;
      preset_select_q <= 1'b0;
      preset_enable_q <= 1'b0;
      precise_stop_q <= 1'b0;
      ref_sum_mask_q <= '0;
      fb_sum_mask_q <= '0;
    end
    else
    begin
      free_run_halt_q <= coast_d; // R26
      alarm_clear_q <= clr_d;
      quick_stop_q <= quick_d;
      direct_current_braking_q <= dcb_d;
      ramp_stop_q <= rstop_d;
      run_q <= run_req & dir_ok & ~stop_any & ~conflict; // R11 R12 R16
      reverse_q <= dir_rev; // R14
      inch_speed_override_q <= hi[difd_pkg::FN_INCH] & ~stop_any; // R18
      freeze_ref_q <= hi[difd_pkg::FN_FREEZE_REF]; // R19
      freeze_out_q <= hi[difd_pkg::FN_FREEZE_OUT]; // R20
      speed_up_ramp_q <= hi[difd_pkg::FN_SPEED_UP] & frozen; // R22 R23
      speed_down_ramp_q <= hi[difd_pkg::FN_SPEED_DN] & frozen; // R22 R23
      speed_up_step_q <= up_step & frozen; // R22
      speed_down_step_q <= dn_step & frozen; // R22
      setup_select_q <= hi[difd_pkg::FN_SETUP_SEL];
      catch_up_q <= hi[difd_pkg::FN_CATCH_UP] & ~hi[difd_pkg::FN_SLOW_DN]; // R25
      slow_down_q <= hi[difd_pkg::FN_SLOW_DN]; // R25
      preset_select_q <= hi[difd_pkg::FN_PRESET_SEL]; // R24
      preset_enable_q <= hi[difd_pkg::FN_PRESET_EN]; // R24
      precise_stop_q <= lo[difd_pkg::FN_PRECISE_STOP];
      ref_sum_mask_q <= ref_mask; // R21
      fb_sum_mask_q <= fb_mask; // R21
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM read path
  // ----------------------------------------------------------------
  logic [31:0] status_w;
  logic [31:0] rd_mux;
  logic [1:0] code_idx;
  logic code_rd;

  assign code_rd = (avs_address <= difd_pkg::OFS_FUNC_T5) && (avs_address[1:0] == 2'h0);
  assign code_idx = avs_address[3:2];

  always_comb
  begin
    status_w = '0;
    status_w[difd_pkg::ST_COAST] = free_run_halt_q;
    status_w[difd_pkg::ST_ALARM_CLR] = alarm_clear_q;
    status_w[difd_pkg::ST_QUICK] = quick_stop_q;
    status_w[difd_pkg::ST_DCB] = direct_current_braking_q;
    status_w[difd_pkg::ST_RAMP_STOP] = ramp_stop_q;
    status_w[difd_pkg::ST_RUN] = run_q;
    status_w[difd_pkg::ST_REV] = reverse_q;
    status_w[difd_pkg::ST_INCH] = inch_speed_override_q;
    status_w[difd_pkg::ST_FRZ_REF] = freeze_ref_q;
    status_w[difd_pkg::ST_FRZ_OUT] = freeze_out_q;
    status_w[difd_pkg::ST_UP_RAMP] = speed_up_ramp_q;
    status_w[difd_pkg::ST_DN_RAMP] = speed_down_ramp_q;
    status_w[difd_pkg::ST_SETUP] = setup_select_q;
    status_w[difd_pkg::ST_CATCH] = catch_up_q;
    status_w[difd_pkg::ST_SLOW] = slow_down_q;
    status_w[difd_pkg::ST_PRE_SEL] = preset_select_q;
    status_w[difd_pkg::ST_PRE_EN] = preset_enable_q;
    status_w[difd_pkg::ST_PRECISE] = precise_stop_q;
    status_w[difd_pkg::ST_LATCHED] = latch_run_q | latch_rev_q;
    status_w[difd_pkg::ST_REF_MASK +: NT] = ref_sum_mask_q;
    status_w[difd_pkg::ST_FB_MASK +: NT] = fb_sum_mask_q;
  end

  // Unmapped offsets and the write-only restore word read as zero
  assign rd_mux = code_rd ? {26'h000_0000, code_q[code_idx]} :
                  (avs_address == difd_pkg::OFS_STATUS) ? status_w :
                  (avs_address == difd_pkg::OFS_LEVELS) ? {28'h000_0000, lvl_q} :
                  32'h0000_0000;

  // One wait cycle per access: waitrequest drops for exactly one edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write)
    begin
      avs_waitrequest <= 1'b0;
      if (rd_take)
        avs_readdata <= rd_mux;
    end
  end

endmodule : difd_top

`default_nettype wire

// ==== dv/difd_chk.sv ====
// Checker for the terminal function decoder outputs.
// Assumes it is bound into difd_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module difd_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic alarm_active,
  input wire logic alarm_power_cycle_only,
  input wire logic dc_brake_configured,
  input wire logic free_run_halt_q,
  input wire logic quick_stop_q,
  input wire logic direct_current_braking_q,
  input wire logic ramp_stop_q,
  input wire logic run_q,
  input wire logic inch_speed_override_q,
  input wire logic alarm_clear_q,
  input wire logic speed_up_ramp_q,
  input wire logic speed_down_ramp_q,
  input wire logic freeze_ref_q,
  input wire logic freeze_out_q,
  input wire logic catch_up_q,
  input wire logic slow_down_q
);
  // ---------
  // Command relations
  // ---------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_JOG: assert property (inch_speed_override_q |-> !(free_run_halt_q || ramp_stop_q))
    else $error("jog while stopped");
  AST_JOGQ: assert property (inch_speed_override_q |-> !(quick_stop_q || direct_current_braking_q))
    else $error("jog under quick or dc stop");
  AST_RUN: assert property (run_q |-> !ramp_stop_q)
    else $error("run under ramp stop");
  AST_COAST: assert property (run_q |-> !free_run_halt_q)
    else $error("run while coasting");
  AST_DCB: assert property (direct_current_braking_q |-> $past(dc_brake_configured))
    else $error("dc brake not configured");
  AST_ALM: assert property (alarm_clear_q |-> $past(alarm_active && !alarm_power_cycle_only))
    else $error("bad alarm clear");
  AST_UPDN: assert property ((speed_up_ramp_q || speed_down_ramp_q) |-> (freeze_ref_q || freeze_out_q))
    else $error("up down without freeze");
  AST_CS: assert property (catch_up_q |-> !slow_down_q)
    else $error("catch and slow together");
endmodule : difd_chk

bind difd_top difd_chk chk (.*);
`default_nettype wire

// ==== dv/difd_term_drv.sv ====
// Switch model driving the four terminal levels.
// Assumes the bench requests levels; each change lands on a clock edge.
`timescale 1ns/1ps
`default_nettype none

module difd_term_drv (
  input wire logic sys_clk,
  input wire logic [3:0] want,
  output var logic [3:0] term_in
);
  // Bench keeps pulse lengths; no contact bounce is modelled
  initial term_in = 4'h0;
  always @(posedge sys_clk)
    term_in <= want;
endmodule : difd_term_drv
`default_nettype wire

// ==== dv/difd_top_tb.sv ====
// Self-checking bench for difd_top with a behavioural command model.
// Assumes a short pulse qualifier (20 cycles) to keep the run brief.
`timescale 1ns/1ps
`default_nettype none

module difd_top_tb;
  logic sys_clk = 0, rst_n = 0, rd = 0, wr = 0, a = 0, p = 0, cfg = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat, r;
  logic [3:0] want = 4'h0;
  wire logic [3:0] term;
  wire logic [31:0] q;
  wire logic wrq;
  wire logic [17:0] o;
  int err_count = 0, samples_checked = 0, i, s;
  logic [5:0] dflt [4] = '{6'h1e, 6'h01, 6'h07, 6'h0d};
  logic [5:0] cod [6][4] = '{'{6'h02, 6'h07, 6'h09, 6'h0d}, '{6'h04, 6'h05, 6'h10, 6'h0e},
    '{6'h01, 6'h13, 6'h14, 6'h06}, '{6'h0f, 6'h11, 6'h17, 6'h12}, '{6'h15, 6'h16, 6'h00, 6'h00},
    '{6'h06, 6'h08, 6'h00, 6'h00}};

  always #5 sys_clk = ~sys_clk;

  difd_term_drv drv (.sys_clk, .want, .term_in(term));
  difd_top #(.PULSE_MIN_CYC(22'h00_0014)) uut (.sys_clk, .rst_n, .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(q), .avs_waitrequest(wrq),
    .term_in(term), .alarm_active(a), .alarm_power_cycle_only(p), .dc_brake_configured(cfg),
    .free_run_halt_q(o[11]), .run_q(o[10]), .reverse_q(o[9]), .inch_speed_override_q(o[8]),
    .quick_stop_q(o[7]), .direct_current_braking_q(o[6]), .speed_up_ramp_q(o[5]), .freeze_ref_q(o[4]),
    .alarm_clear_q(o[3]), .catch_up_q(o[2]), .slow_down_q(o[1]), .ramp_stop_q(o[0]), .freeze_out_q(o[15]),
    .speed_down_ramp_q(o[14]), .speed_up_step_q(), .speed_down_step_q(), .setup_select_q(o[12]),
    .preset_select_q(o[17]), .preset_enable_q(o[16]), .precise_stop_q(o[13]), .ref_sum_mask_q(),
    .fb_sum_mask_q());

  // ---------
  // Tasks and model
  // ---------
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e)
    begin
      err_count++;
      $display("ERROR %s exp %h got %h", nm, e, v);
    end
  endtask : chk

  // Request held until waitrequest is sampled low; a hang ends the run
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    adr <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (wrq === 1'b0)
        break;
    end
    if (n == 20)
    begin
      err_count++;
      results();
    end
    rdat = q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic step(input logic [3:0] v, input int n);
    want <= v;
    repeat (n) @(posedge sys_clk);
  endtask : step

  // Expected commands; r holds levels, alarm, power-cycle and brake config
  function automatic logic [17:0] model(input int sn, input logic [6:0] v);
    logic [17:0] e;
    e = 18'h0_0000;
    if (sn == 0)
      e[11:8] = {!v[0], v[1] & v[0], v[2], v[3] & v[0]};
    else if (sn == 1)
      e[7:4] = {!v[0], !v[1] & v[6], v[2] & v[3], v[3]};
    else if (sn == 2)
      e[3:0] = {v[0] & v[4] & !v[5], v[1] & !v[2], v[2], !v[3]};
    else if (sn == 3)
      e[15:12] = {v[0], v[1] & v[0], !v[2], v[3]};
    else
      e[17:16] = {v[0], v[1]};
    return e;
  endfunction : model

  initial
  begin
    r = $urandom(61);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0000_0000);
      chk("factory", 32'(dflt[i]), rdat);
    end
    bus(1'b0, 8'h14, 32'h0000_0000);
    chk("refmask", 32'h0000_0001, 32'(rdat[23:20]));
    bus(1'b1, 8'h00, 32'h0000_0017);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk("restrict", 32'h0000_001e, rdat);
    bus(1'b1, 8'h04, 32'h0000_0018);
    bus(1'b0, 8'h14, 32'h0000_0000);
    chk("refmask", 32'h0000_0003, 32'(rdat[23:20]));
    bus(1'b0, 8'h1c, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rdat);
    for (s = 0; s < 6; s++)
    begin
      for (i = 0; i < 4; i++)
        bus(1'b1, 8'(i * 4), 32'(cod[s][i]));
      for (i = 0; i < 12 && s < 5; i++)
      begin
        r = $urandom;
        a <= r[4];
        p <= r[5];
        cfg <= r[6];
        step(r[3:0], 8);
        chk("cmd", 32'(model(s, r[6:0])), 32'(o));
      end
    end
    step(4'h1, 10);
    step(4'h3, 10);
    step(4'h1, 30);
    chk("latch", 32'h0000_0000, 32'(o[10]));
    step(4'h3, 25);
    step(4'h1, 10);
    chk("latch", 32'h0000_0001, 32'(o[10]));
    step(4'h0, 3);
    step(4'h1, 10);
    chk("latch", 32'h0000_0000, 32'(o[10]));
    results();
  end
endmodule : difd_top_tb
`default_nettype wire
